// file: hdl/dpo_pkg.sv
`default_nettype none
package dpo_pkg;
  // register byte offsets
  localparam logic [11:0] DPO_CTRL_OFS    = 12'h000;
  localparam logic [11:0] DPO_STAT_OFS    = 12'h004;
  localparam logic [11:0] DPO_SPAN_OFS    = 12'h008;
  localparam logic [11:0] DPO_RANGE_OFS   = 12'h00C;
  localparam logic [11:0] DPO_MOFS_OFS    = 12'h010;
  localparam logic [11:0] DPO_DLY_OFS     = 12'h014;
  localparam logic [11:0] DPO_PHASE_OFS   = 12'h018;
  localparam logic [11:0] DPO_DATA_OFS    = 12'h01C;
  localparam logic [11:0] DPO_CAL_OFS     = 12'h020;
  // control field positions
  localparam int DPO_CTRL_AZ_BIT   = 0;
  localparam int DPO_CTRL_ALL_BIT  = 1;
  localparam int DPO_CTRL_ARM_BIT  = 2;
  localparam int DPO_CTRL_DCPL_BIT = 3;
  // reset values
  localparam logic DPO_PASS_SEL_RST = 1'b0; // last_pass_only
  localparam logic [4:0] DPO_SPAN_RST = 5'h00;
  // counts
  localparam int DPO_STAGES     = 8;
  localparam int DPO_RANGES     = 8;
  localparam int DPO_AZ_SAMPLES = 16;
  localparam int DPO_AZ_SHIFT   = 4;
  localparam int DPO_SETTLE_CYC = 8;
  localparam int DPO_FIFO_DEPTH = 16;
  typedef enum logic [3:0] {
    DPO_IDLE   = 4'b0001,
    DPO_SETTLE = 4'b0010,
    DPO_MEAS   = 4'b0100,
    DPO_RESTOR = 4'b1000
  } dpo_az_t;
endpackage
`default_nettype wire

// file: hdl/dpo_fifo.sv
`default_nettype none
module dpo_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // write side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // read side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;
  logic [W-1:0] rd_reg;
  logic         rv_reg;
  logic         empty;
  logic         take;
  // full when pointers differ only in wrap bit
  assign in_ready = !((wp_reg[AW] != rp_reg[AW]) &&
                      (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign empty    = (wp_reg == rp_reg);
  // output register refills when drained or empty
  assign take      = !empty && (!rv_reg || out_ready);
  assign out_valid = rv_reg;
  assign out_data  = rd_reg;
  // storage write
  always_ff @(posedge pclk) begin
    if (in_valid && in_ready) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
  // pointers and output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      rd_reg <= '0;
      rv_reg <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (take) begin
        rd_reg <= mem[rp_reg[AW-1:0]];
        rp_reg <= rp_reg + 1'b1;
        rv_reg <= 1'b1;
      end else if (out_ready) begin
        rv_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/dpo_core.sv
// The APB interface to the registers and the register addresses were decided locally.
`default_nettype none
module dpo_core
  import dpo_pkg::*;
#(
  parameter int DW = 24,
  parameter int NS = DPO_STAGES
) (
  // apb clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // converter side
  input  wire logic          adc_valid,
  input  wire logic [DW-1:0] adc_data,
  input  wire logic          trig_pin,
  input  wire logic          sync_pin,
  output logic               adc_ground,
  output logic      [DW-1:0] adc_offset
);
  localparam int TW = 5;
  localparam int RW = $clog2(DPO_RANGES);
  localparam int FW = 32;

  // every piece of block state lives in this one record; the offset table
  // and the stage pipeline sit outside it because they are indexed
  typedef struct packed {
    dpo_az_t                       az;
    logic [7:0]                    cnt;
    logic [DW+DPO_AZ_SHIFT-1:0]    acc;
    logic [RW-1:0]                 cal_rng;
    logic [RW-1:0]                 saved_rng;
    logic [RW-1:0]                 range;
    logic                          all_sel;
    logic                          coupled;
    logic                          armed;
    logic                          cal_done;
    logic [4:0]                    span;
    logic [DW-1:0]                 man_ofs;
    logic [DW-1:0]                 adc_ofs;
    logic [31:0]                   dly_pts;
    logic [31:0]                   dly_cnt;
    logic [NS-1:0]                 dec_cnt;
    logic [15:0]                   phase;
    logic                          trig_seen;
    logic                          phase_ok;
    logic [31:0]                   prdata;
    logic [1:0]                    trig_s;
    logic [1:0]                    sync_s;
    logic                          trig_d;
  } dpo_st_t;

  dpo_st_t st_reg;
  dpo_st_t st_next;
  logic [DW-1:0] cal_mem [DPO_RANGES];
  logic [DW-1:0] stg_data [NS+1];
  logic [NS:0]   stg_vld;
  logic          f_in_valid;
  logic          f_in_ready;
  logic [FW-1:0] f_in_data;
  logic          f_out_valid;
  logic          f_out_ready;
  logic [FW-1:0] f_out_data;
  logic          wr_acc;
  logic          rd_acc;
  logic [TW-1:0] sel_tag;
  logic          sel_vld;
  logic [DW-1:0] sel_data;
  logic [TW-1:0] last_tag;
  logic [TW:0]   keep_lim;
  logic          trig_rise;

  // apb: every access completes in its first access cycle; read data are
  // captured at the setup edge, so the access phase only presents them
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = st_reg.prdata;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign stg_data[0] = adc_data;
  assign stg_vld[0]  = adc_valid && (st_reg.az == DPO_IDLE);
  assign adc_ground  = (st_reg.az != DPO_IDLE);
  assign adc_offset  = st_reg.adc_ofs;
  assign last_tag    = TW'(NS);
  // threshold one bit wider than the tag, so a span setting of 31 keeps
  // every pass instead of wrapping round to none
  assign keep_lim    = {1'b0, st_reg.span} + 6'h01;
  // rising edge of the synchronised trigger; trig_d resets low, the idle
  // level of the pin, so no false edge follows reset
  assign trig_rise   = st_reg.trig_s[1] && !st_reg.trig_d;

  // halving stages: each outputs the mean of every pair of input samples
  // one shared counter paces all stages, so a group sync realigns them
  // together and every module of the group sees the same phase
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_stage
      logic [DW-1:0] hold_reg;
      logic          v_reg;
      logic [DW-1:0] d_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hold_reg <= '0;
          d_reg    <= '0;
          v_reg    <= 1'b0;
        end else begin
          v_reg <= 1'b0;
          if (stg_vld[g]) begin
            if (st_reg.dec_cnt[g]) begin
              d_reg <= DW'(({hold_reg[DW-1], hold_reg} +
                             {stg_data[g][DW-1], stg_data[g]}) >> 1);
              v_reg <= 1'b1;
            end else begin
              hold_reg <= stg_data[g];
            end
          end
        end
      end
      assign stg_data[g+1] = d_reg;
      assign stg_vld[g+1]  = v_reg;
    end
  endgenerate

  // shared output sequence: lowest qualifying stage with data wins
  // the loop runs downwards so the lowest ready stage is written last
  always_comb begin
    sel_vld  = 1'b0;
    sel_tag  = '0;
    sel_data = '0;
    for (int s = NS; s >= 1; s--) begin
      if (stg_vld[s]) begin
        if (st_reg.all_sel ? ({1'b0, TW'(s)} <= keep_lim)
                           : (TW'(s) == last_tag)) begin
          sel_vld  = 1'b1;
          sel_tag  = TW'(s);
          sel_data = stg_data[s];
        end
      end
    end
  end

  // samples enter the buffer only when armed and the delay has run out
  // the delay count only runs on final-stage samples, whole output periods
  assign f_in_valid = sel_vld && st_reg.armed && st_reg.trig_seen &&
                      (st_reg.dly_cnt == 32'h0000_0000) &&
                      (st_reg.az == DPO_IDLE);
  assign f_in_data  = {st_reg.all_sel ? sel_tag : 5'h00,
                       3'h0, sel_data};
  assign f_out_ready = psel && penable && !pwrite &&
                       (paddr == DPO_DATA_OFS);

  // host buffer; when it is full new samples are dropped, since the
  // halving stages run at the converter's pace and cannot be stalled
  dpo_fifo #(.W(FW), .D(DPO_FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // per-range offset table, written only by calibration
  // limitation: entries stay unknown until the first calibration, and
  // cal_done keeps them off the converter until then
  always_ff @(posedge pclk) begin
    if (st_reg.az == DPO_MEAS && st_reg.cnt == 8'(DPO_AZ_SAMPLES)) begin
      cal_mem[st_reg.cal_rng] <=
        DW'(-(st_reg.acc >>> DPO_AZ_SHIFT));
    end
  end

  // next state: bus, calibration, trigger timing
  // later assignments override earlier ones, so block order sets priority
  always_comb begin
    st_next = st_reg;
    // pins pass two flops before use; only the second flop is read
    st_next.trig_s = {st_reg.trig_s[0], trig_pin};
    st_next.sync_s = {st_reg.sync_s[0], sync_pin};
    st_next.trig_d = st_reg.trig_s[1];
    // decimation counter, realigned by group sync
    // the same counter is what the trigger phase reports
    if (st_reg.sync_s[1]) begin
      st_next.dec_cnt = '0;
    end else if (adc_valid) begin
      st_next.dec_cnt = st_reg.dec_cnt + 1'b1;
    end
    // delay counts whole output samples only
    if (st_reg.trig_seen && sel_vld && sel_tag == last_tag &&
        st_reg.dly_cnt != 32'h0000_0000) begin
      st_next.dly_cnt = st_reg.dly_cnt - 1'b1;
    end
    // auto-zero sequence
    // each range: settle, then average a fixed number of grounded samples
    case (st_reg.az)
      DPO_IDLE: ;
      DPO_SETTLE: begin
        st_next.cnt = st_reg.cnt + 1'b1;
        if (st_reg.cnt == 8'(DPO_SETTLE_CYC)) begin
          st_next.az  = DPO_MEAS;
          st_next.cnt = '0;
          st_next.acc = '0;
        end
      end
      DPO_MEAS: begin
        if (st_reg.cnt == 8'(DPO_AZ_SAMPLES)) begin
          st_next.cnt = '0;
          if (st_reg.cal_rng == RW'(DPO_RANGES - 1)) begin
            st_next.az = DPO_RESTOR;
          end else begin
            st_next.cal_rng = st_reg.cal_rng + 1'b1;
            st_next.az      = DPO_SETTLE;
          end
        end else if (adc_valid) begin
          st_next.acc = st_reg.acc +
            (DW+DPO_AZ_SHIFT)'(signed'(adc_data));
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      DPO_RESTOR: begin
        st_next.range    = st_reg.saved_rng;
        st_next.cal_done = 1'b1;
        st_next.az       = DPO_IDLE;
      end
      default: st_next.az = DPO_IDLE;
    endcase
    // offset to the converter
    // a grounded input gets a zero offset so calibration sees the raw error
    if (st_reg.az == DPO_IDLE) begin
      st_next.adc_ofs = st_reg.cal_done ? cal_mem[st_reg.range]
                                        : st_reg.man_ofs;
    end else begin
      st_next.adc_ofs = '0;
    end
    // register writes
    // range and auto-zero controls are refused while calibration runs
    if (wr_acc) begin
      case (paddr)
        DPO_CTRL_OFS: begin
          st_next.all_sel = pwdata[DPO_CTRL_ALL_BIT];
          st_next.coupled = !pwdata[DPO_CTRL_DCPL_BIT];
          if (pwdata[DPO_CTRL_AZ_BIT] && st_reg.az == DPO_IDLE) begin
            st_next.saved_rng = st_reg.range;
            st_next.cal_rng   = '0;
            st_next.cnt       = '0;
            st_next.az        = DPO_SETTLE;
            st_next.armed     = 1'b0;
          end else if (pwdata[DPO_CTRL_ARM_BIT] &&
                       st_reg.az == DPO_IDLE) begin
            st_next.armed     = 1'b1;
            st_next.trig_seen = 1'b0;
            st_next.phase_ok  = 1'b0;
          end
        end
        DPO_SPAN_OFS:  st_next.span    = pwdata[4:0];
        DPO_RANGE_OFS: if (st_reg.az == DPO_IDLE) begin
          st_next.range = pwdata[RW-1:0];
        end
        DPO_MOFS_OFS: begin
          st_next.man_ofs  = pwdata[DW-1:0];
          // a calibration finishing in this cycle keeps its result
          if (st_reg.az != DPO_RESTOR) begin
            st_next.cal_done = 1'b0;
          end
        end
        DPO_DLY_OFS:   st_next.dly_pts = pwdata;
        default: ;
      endcase
    end
    // trigger: capture phase in converter clocks of the output period;
    // it comes after the register writes so that an edge landing in the
    // cycle of a re-arm still counts if no trigger was seen since the last arming, the event beating the clear
    if (st_reg.armed && !st_reg.trig_seen && trig_rise) begin
      st_next.trig_seen = 1'b1;
      st_next.dly_cnt   = st_reg.dly_pts;
      // only packing and decimation position, no fixed latency
      st_next.phase    = 16'(st_reg.dec_cnt);
      st_next.phase_ok = st_reg.coupled;
    end
    // read data registered at setup, valid in access phase
    if (rd_acc) begin
      case (paddr)
        DPO_CTRL_OFS: st_next.prdata = {28'h000_0000, !st_reg.coupled,
                                        st_reg.armed, st_reg.all_sel,
                                        1'b0};
        DPO_STAT_OFS: st_next.prdata = {25'h000_0000, !f_in_ready,
                                        f_out_valid, st_reg.phase_ok,
                                        st_reg.trig_seen,
                                        st_reg.cal_done,
                                        st_reg.az != DPO_IDLE, 1'b0};
        DPO_SPAN_OFS:  st_next.prdata = {27'h000_0000, st_reg.span};
        DPO_RANGE_OFS: st_next.prdata = 32'(st_reg.range);
        DPO_MOFS_OFS:  st_next.prdata = 32'(st_reg.man_ofs);
        DPO_DLY_OFS:   st_next.prdata = st_reg.dly_pts;
        DPO_PHASE_OFS: st_next.prdata = {15'h0000, st_reg.phase_ok,
                                         st_reg.phase};
        DPO_DATA_OFS:  st_next.prdata = f_out_valid ? f_out_data
                                                    : 32'h0000_0000;
        DPO_CAL_OFS:   st_next.prdata = 32'(cal_mem[st_reg.range]);
        default:       st_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register
  // reset clears the record, then sets the fields whose idle value differs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.az      <= DPO_IDLE;
      st_reg.all_sel <= DPO_PASS_SEL_RST;
      st_reg.span    <= DPO_SPAN_RST;
      st_reg.coupled <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// file: dv/dpo_core_assertions.sv
`default_nettype none
module dpo_core_assertions
  import dpo_pkg::*;
#(
  parameter int DW = 24
) (
  // apb side
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // converter side
  input wire logic          adc_valid,
  input wire logic [DW-1:0] adc_data,
  input wire logic          trig_pin,
  input wire logic          sync_pin,
  input wire logic          adc_ground,
  input wire logic [DW-1:0] adc_offset
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AZ_MIN = DPO_SETTLE_CYC + DPO_RANGES * DPO_AZ_SAMPLES;
  logic          wr;
  logic          rd;
  logic [DW-1:0] mofs;
  logic [15:0]   gcnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed apb accesses
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // last manual offset, and length of the current grounded run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mofs <= '0;
      gcnt <= 16'h0000;
    end else begin
      gcnt <= adc_ground ? gcnt + 16'h0001 : 16'h0000;
      if (wr && paddr == DPO_MOFS_OFS)
        mofs <= pwdata[DW-1:0];
    end
  end
  AST_READY: assert property (psel |-> pready && !pslverr)
    else $error("access not completed cleanly");
  AST_RDATA_HOLD: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");
  AST_UNMAPPED: assert property (
    rd && paddr > DPO_CAL_OFS |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_AZ_START: assert property (
    wr && paddr == DPO_CTRL_OFS && pwdata[DPO_CTRL_AZ_BIT] && !adc_ground
    |-> ##[1:3] adc_ground) else $error("input not grounded");
  AST_AZ_SETTLE: assert property (
    $rose(adc_ground) |-> adc_ground [*8])
    else $error("ground released during settling");
  AST_AZ_LENGTH: assert property (
    $fell(adc_ground) |-> gcnt >= 16'(AZ_MIN))
    else $error("auto-zero too short for all ranges");
  AST_BUSY: assert property (
    rd && paddr == DPO_STAT_OFS && adc_ground && $past(adc_ground)
    |-> prdata[1]) else $error("busy flag low during auto-zero");
  AST_MANUAL: assert property (
    wr && paddr == DPO_MOFS_OFS && !adc_ground && !$past(wr, 2)
    |=> ##[0:1] adc_offset == mofs) else $error("manual offset lost");
  AST_OFS_STILL: assert property (
    !wr && !$past(wr) && !$past(wr, 2) && !adc_ground
    && !$past(adc_ground) && !$past(adc_ground, 2)
    |=> $stable(adc_offset)) else $error("offset moved without cause");
  // main scenarios reached
  COV_AZ: cover property ($fell(adc_ground));
  COV_POP: cover property (rd && paddr == DPO_DATA_OFS);
  COV_RANGE: cover property (wr && paddr == DPO_RANGE_OFS);
endmodule
`default_nettype wire

// file: dv/dpo_adc_model.sv
`default_nettype none
module dpo_adc_model #(
  parameter logic [23:0] BIAS = 24'h00_0123
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pacing, zero stops the stream
  input  wire logic [7:0]  gap,
  // device side
  input  wire logic        adc_ground,
  output logic             adc_valid,
  output logic      [23:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt;
  logic [23:0] ramp;
  // one strobe per gap cycles; off the strobe the data toggles, so
  // nothing downstream may rely on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 8'h00;
      ramp      <= 24'h00_0000;
      adc_valid <= 1'b0;
      adc_data  <= 24'h00_0000;
    end else begin
      cnt       <= (cnt + 8'h01 >= gap) ? 8'h00 : cnt + 8'h01;
      adc_valid <= gap != 8'h00 && cnt == 8'h00;
      ramp      <= ramp + 24'h00_0101;
      if (gap != 8'h00 && cnt == 8'h00)
        adc_data <= adc_ground ? BIAS : ramp;
      else
        adc_data <= ~adc_data;
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
module testbench
  import dpo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] BIAS = 24'h00_0123;
  localparam logic [23:0] NCAL = 24'h00_0000 - BIAS;
  // bench-driven inputs
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic        trig_pin = 1'b0;
  logic        sync_pin = 1'b0;
  logic        probe    = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [7:0]  gap      = 8'h00;
  // design outputs and bench state
  logic        pready, pslverr, adc_valid, adc_ground;
  logic [31:0] prdata, q, res;
  logic [23:0] adc_data, adc_offset, v;
  logic [63:0] nt;
  logic [63:0] notes[$];
  int          failures = 0;
  int          n_tests  = 0;
  // 100 MHz
  always #5 pclk = ~pclk;
  dpo_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_valid(adc_valid), .adc_data(adc_data), .trig_pin(trig_pin),
    .sync_pin(sync_pin), .adc_ground(adc_ground), .adc_offset(adc_offset));
  dpo_adc_model #(.BIAS(BIAS)) adc_u (.pclk(pclk), .presetn(presetn),
    .gap(gap), .adc_ground(adc_ground), .adc_valid(adc_valid),
    .adc_data(adc_data));
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic oops(input string s);
    $display("unexpected at %0t: %s", $time, s);
    failures++;
  endtask
  // one apb transfer; an idle cycle after it keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 64) begin
      oops("no pready");
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // a zero mask reads without judging
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
    notes.push_back({m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic ofs(input logic [23:0] e);
    notes.push_back({32'h00FF_FFFF, 8'h00, e});
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
    @(posedge pclk);
  endtask
  // pulse the trigger (t=1) or the group sync (t=0)
  task automatic pin(input logic t);
    if (t)
      trig_pin <= 1'b1;
    else
      sync_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    trig_pin <= 1'b0;
    sync_pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // each read completion or offset probe consumes the oldest note
  always @(posedge pclk) begin
    if ((psel && penable && !pwrite && pready) || probe) begin
      if (notes.size() == 0)
        oops("result without a note");
      else begin
        nt = notes.pop_front();
        res = probe ? {8'h00, adc_offset} : prdata;
        if (nt[63:32] != 32'h0000_0000) begin
          n_tests++;
          if ((res & nt[63:32]) !== (nt[31:0] & nt[63:32]))
            oops($sformatf("got %h want %h", res, nt[31:0]));
        end
      end
    end
  end
  initial begin
    int n;
    void'($urandom(9));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(DPO_CTRL_OFS, 32'h0000_0002, 32'h0000_0000);
    rd(DPO_STAT_OFS, 32'h0000_0006, 32'h0000_0000);
    ofs(24'h00_0000);
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100, 32'hFFFF_FFFF, 32'h0000_0000);
    v = 24'($urandom);
    wr(DPO_MOFS_OFS, {8'h00, v});
    ofs(v);
    // auto-zero while samples flow; the range write must be refused
    gap <= 8'h02;
    wr(DPO_CTRL_OFS, 32'h0000_0001);
    rd(DPO_STAT_OFS, 32'h0000_0002, 32'h0000_0002);
    wr(DPO_RANGE_OFS, 32'h0000_0003);
    n = 0;
    do begin
      rd(DPO_STAT_OFS, 32'h0000_0000, 32'h0000_0000);
      n++;
    end while (q[1] !== 1'b0 && n < 400);
    if (n >= 400) begin
      oops("auto-zero hangs");
      give_verdict();
    end
    rd(DPO_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    rd(DPO_CAL_OFS, 32'h00FF_FFFF, {8'h00, NCAL});
    ofs(NCAL);
    for (int r = 0; r < DPO_RANGES; r++) begin
      wr(DPO_RANGE_OFS, 32'(r));
      ofs(NCAL);
    end
    wr(DPO_MOFS_OFS, {8'h00, v});
    ofs(v);
    // last pass only: nothing before 256 inputs, untagged after
    gap <= 8'h00;
    pin(1'b0);
    wr(DPO_CTRL_OFS, 32'h0000_0004);
    pin(1'b1);
    gap <= 8'h02;
    repeat (400) @(posedge pclk);
    rd(DPO_STAT_OFS, 32'h0000_0020, 32'h0000_0000);
    repeat (1000) @(posedge pclk);
    rd(DPO_STAT_OFS, 32'h0000_0020, 32'h0000_0020);
    rd(DPO_DATA_OFS, 32'hF800_0000, 32'h0000_0000);
    // all passes fill the buffer fast; host stalls, then drains
    wr(DPO_SPAN_OFS, 32'h0000_0007);
    wr(DPO_CTRL_OFS, 32'h0000_0006);
    pin(1'b1);
    repeat (300) @(posedge pclk);
    gap <= 8'h00;
    rd(DPO_STAT_OFS, 32'h0000_0060, 32'h0000_0060);
    repeat (24) rd(DPO_DATA_OFS, 32'h0000_0000, 32'h0000_0000);
    rd(DPO_STAT_OFS, 32'h0000_0060, 32'h0000_0000);
    // phase invalid when decoupled, exact count when coupled
    wr(DPO_CTRL_OFS, 32'h0000_000C);
    pin(1'b1);
    rd(DPO_PHASE_OFS, 32'h0001_0000, 32'h0000_0000);
    wr(DPO_CTRL_OFS, 32'h0000_0000);
    wr(DPO_CTRL_OFS, 32'h0000_0004);
    pin(1'b0);
    gap <= 8'h02;
    repeat (10) @(posedge pclk);
    gap <= 8'h00;
    pin(1'b1);
    rd(DPO_PHASE_OFS, 32'h0001_FFFF, 32'h0001_0005);
    rd(DPO_STAT_OFS, 32'h0000_0018, 32'h0000_0018);
    give_verdict();
  end
endmodule
bind dpo_core dpo_core_assertions #(.DW(DW)) chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .adc_valid(adc_valid), .adc_data(adc_data),
  .trig_pin(trig_pin), .sync_pin(sync_pin), .adc_ground(adc_ground),
  .adc_offset(adc_offset));
`default_nettype wire
